// *** uart_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module uart_host_model (
  // Pacing clock.
  input wire logic i_clk,
  // Bus pins.
  output logic o_cs_n,
  output logic o_ior_n,
  output logic o_iow_n,
  output logic [2:0] o_addr,
  output logic [7:0] o_data,
  input wire logic [7:0] i_data,
  input wire logic i_data_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus with junk on the data lines.
  initial
  begin
    o_cs_n = 1'b1;
    o_ior_n = 1'b1;
    o_iow_n = 1'b1;
    o_addr = 3'h0;
    o_data = 8'hA5;
  end
  // One access; strobes pass a synchroniser, so both phases last six cycles or more.
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        input int hold, output logic [7:0] q);
    @(negedge i_clk);
    o_addr = a;
    o_data = d;
    o_cs_n = 1'b0;
    o_ior_n = wr;
    o_iow_n = !wr;
    repeat (hold) @(negedge i_clk);
    // An undriven bus reads as unknown, never as a stale byte.
    q = i_data_oe ? i_data : 8'hXX;
    o_cs_n = 1'b1;
    o_ior_n = 1'b1;
    o_iow_n = 1'b1;
    repeat (6) @(negedge i_clk);
    o_data = ~d;
  endtask
endmodule
`default_nettype wire

// *** uart_regmap_loopback.sv ***
`timescale 1ns/10ps
`default_nettype none
module uart_regmap_loopback (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Host parallel bus pins.
  input wire logic i_cs_n,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Serial and modem pins.
  input wire logic i_rx_pin,
  output logic o_tx_pin,
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  input wire logic i_carrier_detect_n,
  input wire logic i_ring_indicator_n,
  output logic o_rts_n,
  output logic o_dtr_n,
  // Serial paths to the shifters and modem status logic.
  input wire logic i_tsr_serial,
  output logic o_rsr_serial,
  output logic o_core_cts_n,
  output logic o_core_dsr_n,
  output logic o_core_carrier_detect_n,
  output logic o_core_ring_indicator_n,
  // Values read from the rest of the UART.
  input wire logic [7:0] i_rx_holding,
  input wire logic [7:0] i_irq_status,
  input wire logic [7:0] i_line_status,
  input wire logic [7:0] i_modem_status,
  input wire logic [7:0] i_fifo_level,
  // Access strobes to the rest of the UART.
  output logic o_rx_read,
  output logic o_irq_status_read,
  output logic o_line_status_read,
  output logic o_modem_status_read,
  output logic o_tx_write,
  output logic o_queue_write,
  output logic o_mode_select_write,
  output logic [7:0] o_wr_data,
  // Stored register values.
  output logic [7:0] o_divisor_low,
  output logic [7:0] o_divisor_high,
  output logic [7:0] o_divisor_fraction,
  output logic [7:0] o_irq_enable,
  output logic [7:0] o_line_control,
  output logic [7:0] o_modem_control,
  output logic [7:0] o_feature_control,
  output logic [7:0] o_enhanced_function,
  output logic [7:0] o_resume_char_1,
  output logic [7:0] o_resume_char_2,
  output logic [7:0] o_pause_char_1,
  output logic [7:0] o_pause_char_2,
  output logic [7:0] o_modem_status_ctl,
  output logic o_loopback
);
  import uart_regmap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [18:0] sync1_q;
  logic [18:0] sync2_q;
  logic [18:0] sync3_q;
  logic [18:0] flt_q;
  logic [18:0] flt_d;

  // Three stages; a bit changes only once stages two and three agree.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_q <= SYNC_RESET;
      sync2_q <= SYNC_RESET;
      sync3_q <= SYNC_RESET;
      flt_q <= SYNC_RESET;
    end
    else
    begin
      sync1_q <= {i_data, i_addr, i_iow_n, i_ior_n, i_cs_n, i_rx_pin, i_cts_n,
                  i_dsr_n, i_carrier_detect_n, i_ring_indicator_n};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      flt_q <= flt_d;
    end
  end

  // Bitwise agreement filter.
  assign flt_d = (sync3_q & ~(sync2_q ^ sync3_q)) | (flt_q & (sync2_q ^ sync3_q));

  logic [7:0] host_data;
  logic [2:0] host_addr;
  logic rd_act;
  logic wr_act;
  assign host_data = flt_q[18:11];
  assign host_addr = flt_q[10:8];
  assign wr_act = ~flt_q[5] & ~flt_q[7];
  assign rd_act = ~flt_q[5] & ~flt_q[6];

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.

  logic [7:0] reg_q [REG_COUNT];
  logic div_zero;
  assign div_zero = (reg_q[IDX_DIV_LOW] == REG_RESET) && (reg_q[IDX_DIV_HIGH] == REG_RESET);

  // Picks the register for one access from address and banking state.
  function automatic sel_t decode(input logic [2:0] addr, input logic [7:0] line_ctl,
                                  input logic enh_on, input logic feat_bank,
                                  input logic dzero, input logic wr);
    logic key;
    logic dlab;
    key = (line_ctl == BANK_KEY);
    dlab = line_ctl[DIV_ACCESS_BIT];
    decode = sel_none;
    unique case (addr)
      ADDR_0:
        // (RULE20) Level count in key bank.
        if (key)
          decode = wr ? sel_none : sel_level;
        // (RULE8) (RULE10) Divisor or revision.
        else if (dlab)
          decode = (!wr && dzero) ? sel_revision : sel_div_low;
        // (RULE11) Holding registers.
        else
          decode = wr ? sel_tx_holding : sel_rx_holding;
      ADDR_1:
        // (RULE20) Feature control.
        if (key)
          decode = sel_feature;
        // (RULE8) (RULE10) Divisor high or ident.
        else if (dlab)
          decode = (!wr && dzero) ? sel_ident : sel_div_high;
        // (RULE12) Interrupt enable.
        else
          decode = sel_irq_enable;
      ADDR_2:
        // (RULE20) Enhanced function.
        if (key)
          decode = sel_enh_func;
        // (RULE9) Fractional divisor.
        else if (dlab && enh_on)
          decode = sel_div_frac;
        // (RULE13) Status and queue control.
        else
          decode = wr ? sel_queue_ctl : sel_irq_status;
      // (RULE14) Line control always.
      ADDR_3:
        decode = sel_line_ctl;
      ADDR_4:
        // (RULE21) (RULE15) Resume one or modem control.
        decode = key ? sel_resume_1 : sel_modem_ctl;
      ADDR_5:
        // (RULE21) (RULE16) Resume two or line status.
        if (key)
          decode = sel_resume_2;
        else
          decode = wr ? sel_none : sel_line_status;
      ADDR_6:
        // (RULE21) (RULE17) Pause one or modem status.
        if (key)
          decode = sel_pause_1;
        else if (wr)
          decode = enh_on ? sel_mstat_ctl : sel_none;
        else
          decode = sel_modem_status;
      ADDR_7:
        // (RULE21) Pause two in key bank.
        if (key)
          decode = sel_pause_2;
        // (RULE19) Mode select or level count.
        else if (feat_bank)
          decode = wr ? sel_mode_select : sel_level;
        // (RULE18) Scratch pad.
        else
          decode = sel_scratch;
    endcase
  endfunction

  sel_t rd_sel;
  sel_t wr_sel;
  logic [7:0] wr_data_q;
  logic [2:0] wr_addr_q;
  logic rd_act_q;
  logic wr_act_q;
  logic rd_start;
  logic wr_end;

  assign rd_start = rd_act & ~rd_act_q;
  assign wr_end = ~wr_act & wr_act_q;
  assign rd_sel = decode(host_addr, reg_q[IDX_LINE_CTL], reg_q[IDX_ENH_FUNC][ENH_ENABLE_BIT],
                         reg_q[IDX_FEATURE][FEAT_BANK_BIT], div_zero, 1'b0);
  assign wr_sel = decode(wr_addr_q, reg_q[IDX_LINE_CTL], reg_q[IDX_ENH_FUNC][ENH_ENABLE_BIT],
                         reg_q[IDX_FEATURE][FEAT_BANK_BIT], div_zero, 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // Host strobes.

  // Address and data are captured while the write strobe is low and held after it rises, since the
  // commit happens only after the strobe has risen and the bus may move.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      wr_data_q <= REG_RESET;
      wr_addr_q <= ADDR_0;
    end
    else
    begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (wr_act)
      begin
        wr_data_q <= host_data;
        wr_addr_q <= host_addr;
      end
    end
  end

  logic [7:0] rd_mux;

  // Read data source for the selected register.
  always_comb
  begin
    rd_mux = REG_RESET;
    unique case (rd_sel)
      sel_rx_holding: rd_mux = i_rx_holding;
      sel_div_low: rd_mux = reg_q[IDX_DIV_LOW];
      sel_div_high: rd_mux = reg_q[IDX_DIV_HIGH];
      sel_revision: rd_mux = REVISION_VALUE;
      sel_ident: rd_mux = IDENT_VALUE;
      sel_div_frac: rd_mux = reg_q[IDX_DIV_FRAC];
      sel_irq_enable: rd_mux = reg_q[IDX_IRQ_EN];
      sel_irq_status: rd_mux = i_irq_status;
      sel_line_ctl: rd_mux = reg_q[IDX_LINE_CTL];
      sel_modem_ctl: rd_mux = reg_q[IDX_MODEM_CTL];
      sel_line_status: rd_mux = i_line_status;
      sel_modem_status: rd_mux = i_modem_status;
      sel_scratch: rd_mux = reg_q[IDX_SCRATCH];
      sel_level: rd_mux = i_fifo_level;
      sel_feature: rd_mux = reg_q[IDX_FEATURE];
      sel_enh_func: rd_mux = reg_q[IDX_ENH_FUNC];
      sel_resume_1: rd_mux = reg_q[IDX_RESUME_1];
      sel_resume_2: rd_mux = reg_q[IDX_RESUME_2];
      sel_pause_1: rd_mux = reg_q[IDX_PAUSE_1];
      sel_pause_2: rd_mux = reg_q[IDX_PAUSE_2];
      default: rd_mux = REG_RESET;
    endcase
  end

  // Read data is captured once at the strobe start and held, so a status
  // value cannot change under the host during one read.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_data <= REG_RESET;
      o_data_oe <= 1'b0;
      o_rx_read <= 1'b0;
      o_irq_status_read <= 1'b0;
      o_line_status_read <= 1'b0;
      o_modem_status_read <= 1'b0;
    end
    else
    begin
      o_data_oe <= rd_act;
      if (rd_start)
        o_data <= rd_mux;
      o_rx_read <= rd_start && (rd_sel == sel_rx_holding);
      o_irq_status_read <= rd_start && (rd_sel == sel_irq_status);
      o_line_status_read <= rd_start && (rd_sel == sel_line_status);
      o_modem_status_read <= rd_start && (rd_sel == sel_modem_status);
    end
  end

  // Write strobes toward the transmit holding, queue control and mode select.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tx_write <= 1'b0;
      o_queue_write <= 1'b0;
      o_mode_select_write <= 1'b0;
      o_wr_data <= REG_RESET;
    end
    else
    begin
      o_tx_write <= wr_end && (wr_sel == sel_tx_holding);
      o_queue_write <= wr_end && (wr_sel == sel_queue_ctl);
      o_mode_select_write <= wr_end && (wr_sel == sel_mode_select);
      if (wr_end)
        o_wr_data <= wr_data_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored registers.

  int wr_idx;

  // Index of the stored register a write lands in, or -1 for none.
  always_comb
  begin
    wr_idx = -1;
    unique case (wr_sel)
      sel_div_low: wr_idx = IDX_DIV_LOW;
      sel_div_high: wr_idx = IDX_DIV_HIGH;
      sel_div_frac: wr_idx = IDX_DIV_FRAC;
      sel_irq_enable: wr_idx = IDX_IRQ_EN;
      sel_line_ctl: wr_idx = IDX_LINE_CTL;
      sel_modem_ctl: wr_idx = IDX_MODEM_CTL;
      sel_scratch: wr_idx = IDX_SCRATCH;
      sel_feature: wr_idx = IDX_FEATURE;
      sel_enh_func: wr_idx = IDX_ENH_FUNC;
      sel_resume_1: wr_idx = IDX_RESUME_1;
      sel_resume_2: wr_idx = IDX_RESUME_2;
      sel_pause_1: wr_idx = IDX_PAUSE_1;
      sel_pause_2: wr_idx = IDX_PAUSE_2;
      sel_mstat_ctl: wr_idx = IDX_MSTAT_CTL;
      default: wr_idx = -1;
    endcase
  end

  // (RULE1) Stored register writes, modem control with the loopback bit among them.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        reg_q[i] <= REG_RESET;
    end
    else if (wr_end && (wr_idx >= 0))
      reg_q[wr_idx] <= wr_data_q;
  end

  assign o_divisor_low = reg_q[IDX_DIV_LOW];
  assign o_divisor_high = reg_q[IDX_DIV_HIGH];
  assign o_divisor_fraction = reg_q[IDX_DIV_FRAC];
  assign o_irq_enable = reg_q[IDX_IRQ_EN];
  assign o_line_control = reg_q[IDX_LINE_CTL];
  assign o_modem_control = reg_q[IDX_MODEM_CTL];
  assign o_feature_control = reg_q[IDX_FEATURE];
  assign o_enhanced_function = reg_q[IDX_ENH_FUNC];
  assign o_resume_char_1 = reg_q[IDX_RESUME_1];
  assign o_resume_char_2 = reg_q[IDX_RESUME_2];
  assign o_pause_char_1 = reg_q[IDX_PAUSE_1];
  assign o_pause_char_2 = reg_q[IDX_PAUSE_2];
  assign o_modem_status_ctl = reg_q[IDX_MSTAT_CTL];
  assign o_loopback = reg_q[IDX_MODEM_CTL][LOOPBACK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Loopback routing.

  logic [7:0] mctl;
  assign mctl = reg_q[IDX_MODEM_CTL];

  // Only the pin paths are rerouted; FIFOs, flags and interrupts downstream
  // get the looped-back serial and modem signals on the same ports as in normal operation.
  // (RULE6) Transparent rerouting.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tx_pin <= 1'b1;
      o_rsr_serial <= 1'b1;
      o_rts_n <= 1'b1;
      o_dtr_n <= 1'b1;
      o_core_cts_n <= 1'b1;
      o_core_dsr_n <= 1'b1;
      o_core_carrier_detect_n <= 1'b1;
      o_core_ring_indicator_n <= 1'b1;
    end
    else if (o_loopback)
    begin
      // (RULE3) Transmit pin marks.
      o_tx_pin <= 1'b1;
      // (RULE2) Transmit fed back internally.
      o_rsr_serial <= i_tsr_serial;
      // (RULE4) Modem outputs de-asserted.
      o_rts_n <= 1'b1;
      o_dtr_n <= 1'b1;
      // (RULE5) Pins ignored, control bits fed back.
      o_core_cts_n <= ~mctl[RTS_BIT];
      o_core_dsr_n <= ~mctl[DTR_BIT];
      o_core_ring_indicator_n <= ~mctl[OUT1_BIT];
      o_core_carrier_detect_n <= ~mctl[OUT2_BIT];
    end
    else
    begin
      o_tx_pin <= i_tsr_serial;
      o_rsr_serial <= flt_q[4];
      o_rts_n <= ~mctl[RTS_BIT];
      o_dtr_n <= ~mctl[DTR_BIT];
      o_core_cts_n <= flt_q[3];
      o_core_dsr_n <= flt_q[2];
      o_core_carrier_detect_n <= flt_q[1];
      o_core_ring_indicator_n <= flt_q[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  logic key_now;
  assign key_now = (reg_q[IDX_LINE_CTL] == BANK_KEY);

  loop_enter_a: assert property (wr_end && wr_sel == sel_modem_ctl |=> // (RULE1)
    o_loopback == $past(wr_data_q[LOOPBACK_BIT])) else $error("loopback bit not taken");
  loop_route_a: assert property (o_loopback ##1 o_loopback |-> // (RULE2)
    o_rsr_serial == $past(i_tsr_serial)) else $error("loopback data not routed");
  tx_mark_a: assert property ($past(o_loopback) |-> o_tx_pin) // (RULE3)
    else $error("transmit pin not marking in loopback");
  modem_out_a: assert property ($past(o_loopback) |-> o_rts_n && o_dtr_n) // (RULE4)
    else $error("modem outputs active in loopback");
  modem_in_a: assert property ($past(o_loopback) |-> // (RULE5)
    o_core_cts_n == ~$past(mctl[RTS_BIT])) else $error("modem input not isolated");
  divisor_read_a: assert property (rd_start && host_addr == ADDR_0 && !key_now && // (RULE8)
    reg_q[IDX_LINE_CTL][DIV_ACCESS_BIT] && !div_zero |=> o_data == $past(o_divisor_low))
    else $error("divisor low read wrong");
  ident_read_a: assert property (rd_start && host_addr == ADDR_1 && !key_now && // (RULE10)
    reg_q[IDX_LINE_CTL][DIV_ACCESS_BIT] && div_zero |=> o_data == IDENT_VALUE)
    else $error("ident read wrong");
  rx_pulse_a: assert property (rd_start && host_addr == ADDR_0 && // (RULE11)
    !reg_q[IDX_LINE_CTL][DIV_ACCESS_BIT] |=> o_rx_read ##1 !o_rx_read)
    else $error("receive read strobe wrong");
  line_write_a: assert property (wr_end && wr_addr_q == ADDR_3 |=> // (RULE14)
    o_line_control == $past(wr_data_q)) else $error("line control write lost");
  pause_write_a: assert property (wr_end && key_now && wr_addr_q == ADDR_7 |=> // (RULE21)
    o_pause_char_2 == $past(wr_data_q)) else $error("pause two write lost");

  loop_on_c: cover property (!o_loopback ##1 o_loopback);
  ident_rd_c: cover property (rd_start && rd_sel == sel_ident);
  key_wr_c: cover property (wr_end && key_now);
endmodule
`default_nettype wire

// *** uart_regmap_loopback_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module uart_regmap_loopback_bench;
  import uart_regmap_pkg::*;
  logic i_core_clk, i_rst_n, i_cs_n, i_ior_n, i_iow_n, i_rx_pin, i_cts_n, i_dsr_n;
  logic i_carrier_detect_n, i_ring_indicator_n, i_tsr_serial, o_data_oe, o_tx_pin;
  logic o_rts_n, o_dtr_n, o_rsr_serial, o_core_cts_n, o_core_dsr_n, o_core_carrier_detect_n;
  logic o_core_ring_indicator_n, o_loopback, o_rx_read, o_irq_status_read, o_line_status_read;
  logic o_modem_status_read, o_tx_write, o_queue_write, o_mode_select_write;
  logic [2:0] i_addr;
  logic [7:0] i_data, o_data, i_rx_holding, i_irq_status, i_line_status, i_modem_status;
  logic [7:0] i_fifo_level, o_wr_data, o_divisor_low, o_divisor_high, o_divisor_fraction;
  logic [7:0] o_irq_enable, o_line_control, o_modem_control, o_feature_control;
  logic [7:0] o_enhanced_function, o_resume_char_1, o_resume_char_2, o_pause_char_1;
  logic [7:0] o_pause_char_2, o_modem_status_ctl, wd, q;
  logic [6:0] pulses;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int pc[7];
  ////////////////////////////////////////////////////////////////////////////////
  uart_regmap_loopback uut (.*);
  uart_host_model host (.i_clk(i_core_clk), .o_cs_n(i_cs_n), .o_ior_n(i_ior_n),
    .o_iow_n(i_iow_n), .o_addr(i_addr), .o_data(i_data), .i_data(o_data),
    .i_data_oe(o_data_oe));
  // Clock at 40 MHz.
  initial
  begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  assign pulses = {o_mode_select_write, o_queue_write, o_tx_write, o_modem_status_read,
                   o_line_status_read, o_irq_status_read, o_rx_read};
  // Pulse counts catch strobes that stick or double; the run is cut short if it hangs.
  always @(posedge i_core_clk)
  begin
    cycles <= cycles + 1;
    for (int i = 0; i < 7; i++)
      pc[i] <= pc[i] + int'(pulses[i]);
    if (o_tx_write || o_queue_write || o_mode_select_write)
      wd <= o_wr_data;
    if (cycles == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, 6, q);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    host.access(1'b0, a, 8'h00, 6, q);
    chk("read data", e, q);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("reset pins", 8'h0E, {o_data_oe, o_tx_pin, o_rts_n, o_dtr_n, o_loopback});
    chk("reset regs", 8'h00, o_line_control | o_modem_control | o_divisor_low);
    $display("reset test done");
  endtask
  task automatic t_divisor();
    wr(ADDR_3, 8'h80);
    rd(ADDR_3, 8'h80);
    rd(ADDR_0, REVISION_VALUE);
    rd(ADDR_1, IDENT_VALUE);
    wr(ADDR_0, 8'h34);
    rd(ADDR_1, 8'h00);
    wr(ADDR_1, 8'h12);
    rd(ADDR_0, 8'h34);
    rd(ADDR_1, 8'h12);
    chk("divisor high", 8'h12, o_divisor_high);
    rd(ADDR_2, 8'hC1);
    wr(ADDR_6, 8'h3C);
    chk("status ctl off", 8'h00, o_modem_status_ctl);
    $display("divisor test done");
  endtask
  task automatic t_key();
    wr(ADDR_3, BANK_KEY);
    rd(ADDR_0, 8'h0B);
    wr(ADDR_0, 8'hEE);
    chk("level read only", 8'h34, o_divisor_low);
    wr(ADDR_1, 8'h40);
    wr(ADDR_2, 8'h10);
    rd(ADDR_1, 8'h40);
    rd(ADDR_2, 8'h10);
    for (int i = 4; i < 8; i++)
      wr(3'(i), 8'hA0 + 8'(i));
    for (int i = 4; i < 8; i++)
      rd(3'(i), 8'hA0 + 8'(i));
    chk("resume 1", 8'hA4, o_resume_char_1);
    chk("pause 2", 8'hA7, o_pause_char_2);
    chk("feature", 8'h40, o_feature_control);
    chk("enhanced", 8'h10, o_enhanced_function);
    wr(ADDR_3, 8'h80);
    wr(ADDR_2, 8'h2C);
    rd(ADDR_2, 8'h2C);
    chk("fraction", 8'h2C, o_divisor_fraction);
    $display("key bank test done");
  endtask
  task automatic t_normal();
    wr(ADDR_3, 8'h00);
    pc = '{default: 0};
    rd(ADDR_0, 8'h77);
    wr(ADDR_0, 8'h5C);
    chk("tx data", 8'h5C, wd);
    wr(ADDR_1, 8'h0F);
    rd(ADDR_1, 8'h0F);
    chk("irq enable", 8'h0F, o_irq_enable);
    rd(ADDR_2, 8'hC1);
    wr(ADDR_2, 8'h07);
    chk("queue data", 8'h07, wd);
    rd(ADDR_5, 8'h60);
    wr(ADDR_5, 8'hFF);
    rd(ADDR_6, 8'hB0);
    wr(ADDR_6, 8'hF0);
    chk("status ctl", 8'hF0, o_modem_status_ctl);
    rd(ADDR_7, 8'h0B);
    wr(ADDR_7, 8'h03);
    chk("mode data", 8'h03, wd);
    for (int i = 0; i < 7; i++)
      chk("strobe count", 8'h01, 8'(pc[i]));
    wr(ADDR_3, BANK_KEY);
    wr(ADDR_1, 8'h00);
    wr(ADDR_3, 8'h00);
    wr(ADDR_7, 8'h99);
    host.access(1'b0, ADDR_7, 8'h00, 14, q);
    chk("scratch", 8'h99, q);
    $display("normal bank test done");
  endtask
  task automatic t_loop();
    {i_cts_n, i_dsr_n, i_carrier_detect_n, i_ring_indicator_n} = 4'hF;
    wr(ADDR_4, 8'h13);
    rd(ADDR_4, 8'h13);
    chk("loopback", 8'h01, o_loopback);
    chk("modem ctl", 8'h13, o_modem_control);
    for (int b = 0; b < 2; b++)
    begin
      i_tsr_serial = b[0];
      repeat (2) @(negedge i_core_clk);
      chk("receive in", 8'(b), o_rsr_serial);
      chk("tx pin", 8'h01, o_tx_pin);
    end
    chk("rts dtr", 8'h03, {o_rts_n, o_dtr_n});
    chk("core modem", 8'h03, {o_core_cts_n, o_core_dsr_n, o_core_carrier_detect_n,
                              o_core_ring_indicator_n});
    rd(ADDR_2, 8'hC1);
    wr(ADDR_4, 8'h03);
    i_rx_pin = 1'b0;
    i_tsr_serial = 1'b0;
    repeat (6) @(negedge i_core_clk);
    chk("loop off", 8'h00, o_loopback);
    chk("pins", 8'h01, {o_rts_n, o_dtr_n, o_tx_pin, o_rsr_serial, o_core_cts_n});
    i_rx_pin = 1'b1;
    $display("loopback test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the receive pin idles high so leaving loopback sees no break.
  initial
  begin
    i_rst_n = 1'b0;
    i_rx_pin = 1'b1;
    i_tsr_serial = 1'b1;
    {i_cts_n, i_dsr_n, i_carrier_detect_n, i_ring_indicator_n} = 4'hF;
    i_rx_holding = 8'h77;
    i_irq_status = 8'hC1;
    i_line_status = 8'h60;
    i_modem_status = 8'hB0;
    i_fifo_level = 8'h0B;
    pc = '{default: 0};
    repeat (19) @(negedge i_core_clk);
    t_reset();
    @(negedge i_core_clk);
    i_rst_n = 1'b1;
    t_divisor();
    t_key();
    t_normal();
    t_loop();
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** uart_regmap_pkg.sv ***
// Summary of operation
// (RULE1) Modem control bit 4 set enters loopback; clearing it leaves loopback.
// (RULE2) In loopback the transmit shifter output feeds the receive shifter input.
// (RULE3) In loopback the transmit pin stays high (mark).
// (RULE4) In loopback request-to-send and terminal-ready pins stay de-asserted.
// (RULE5) In loopback the four modem input pins are ignored.
// (RULE6) FIFOs, status flags and interrupts keep working during loopback.
// (RULE7) The far end holds the receive pin high throughout loopback.
// (RULE8) Divisor access, key absent: addresses 0 and 1 are divisor low and high.
// (RULE9) Divisor access with enhanced functions on: address 2 is divisor fraction.
// (RULE10) Divisor access with zero divisor: reads at 0 and 1 give revision, ident.
// (RULE11) Line control bit 7 clear: address 0 reads receive, writes transmit holding.
// (RULE12) Address 1 is interrupt enable in the normal bank.
// (RULE13) Address 2 reads interrupt status and writes queue control in normal bank.
// (RULE14) Address 3 is always line control.
// (RULE15) Address 4 is modem control in the normal bank.
// (RULE16) Key absent: address 5 reads line status.
// (RULE17) Address 6 reads modem status; writes go to control when enhanced on.
// (RULE18) Key absent, feature bit 6 clear: address 7 is scratch pad.
// (RULE19) Key absent, feature bit 6 set: address 7 writes mode select, reads level.
// (RULE20) Key present: addresses 0, 1, 2 are level count, feature, enhanced function.
// (RULE21) Key present: addresses 4 to 7 are resume 1, resume 2, pause 1, pause 2.
`default_nettype none
package uart_regmap_pkg;
  // Register addresses on the three address lines.
  localparam logic [2:0] ADDR_0 = 3'h0;
  localparam logic [2:0] ADDR_1 = 3'h1;
  localparam logic [2:0] ADDR_2 = 3'h2;
  localparam logic [2:0] ADDR_3 = 3'h3;
  localparam logic [2:0] ADDR_4 = 3'h4;
  localparam logic [2:0] ADDR_5 = 3'h5;
  localparam logic [2:0] ADDR_6 = 3'h6;
  localparam logic [2:0] ADDR_7 = 3'h7;
  // Line control value that opens the enhanced bank.
  localparam logic [7:0] BANK_KEY = 8'hBF;
  // Field positions.
  localparam int DIV_ACCESS_BIT = 7;
  localparam int ENH_ENABLE_BIT = 4;
  localparam int FEAT_BANK_BIT = 6;
  localparam int LOOPBACK_BIT = 4;
  localparam int DTR_BIT = 0;
  localparam int RTS_BIT = 1;
  localparam int OUT1_BIT = 2;
  localparam int OUT2_BIT = 3;
  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [18:0] SYNC_RESET = 19'h000FF;
  // Identity values; arbitrary, chosen only to be non-zero and distinct.
  localparam logic [7:0] REVISION_VALUE = 8'h01;
  localparam logic [7:0] IDENT_VALUE = 8'h5A;
  // Index of each stored register.
  localparam int REG_COUNT = 14;
  localparam int IDX_DIV_LOW = 0;
  localparam int IDX_DIV_HIGH = 1;
  localparam int IDX_DIV_FRAC = 2;
  localparam int IDX_IRQ_EN = 3;
  localparam int IDX_LINE_CTL = 4;
  localparam int IDX_MODEM_CTL = 5;
  localparam int IDX_SCRATCH = 6;
  localparam int IDX_FEATURE = 7;
  localparam int IDX_ENH_FUNC = 8;
  localparam int IDX_RESUME_1 = 9;
  localparam int IDX_RESUME_2 = 10;
  localparam int IDX_PAUSE_1 = 11;
  localparam int IDX_PAUSE_2 = 12;
  localparam int IDX_MSTAT_CTL = 13;
  // Register selected by one access.
  typedef enum logic [4:0] {
    sel_none, sel_rx_holding, sel_tx_holding, sel_div_low, sel_div_high,
    sel_revision, sel_ident, sel_div_frac, sel_irq_enable, sel_irq_status,
    sel_queue_ctl, sel_line_ctl, sel_modem_ctl, sel_line_status, sel_modem_status,
    sel_mstat_ctl, sel_scratch, sel_mode_select, sel_level, sel_feature,
    sel_enh_func, sel_resume_1, sel_resume_2, sel_pause_1, sel_pause_2
  } sel_t;
endpackage
`default_nettype wire
